// ===== hw/ssap_pkg.sv
package ssap_pkg;

    // Core clock rate, in cycles per microsecond
    localparam int CLK_MHZ         = 40;
    localparam int GATE_TIME_NS    = 1000;
    localparam int ACCESS_TMO_US   = 300;
    // Least time rounds up, longest time rounds down
    localparam int GATE_CYC        = (GATE_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int ACCESS_TMO_CYC  = ACCESS_TMO_US * CLK_MHZ;

    localparam int CNT_W           = 18;
    localparam int TMO_W           = 14;
    localparam int TICK_W          = 9;
    localparam int BCNT_W          = 5;
    localparam int FRAME_BITS      = 16;
    localparam int CRC_BITS        = 4;
    localparam int FRAME_CRC_BITS  = FRAME_BITS + CRC_BITS;

    localparam logic [CNT_W-1:0]  GATE_CYC_V = CNT_W'(GATE_CYC);
    localparam logic [BCNT_W-1:0] BCNT_16    = 5'h10;
    localparam logic [BCNT_W-1:0] BCNT_20    = 5'h14;
    localparam logic [BCNT_W-1:0] BCNT_MAX   = 5'h1f;

    localparam logic [3:0]  CRC_PRESET  = 4'hf;
    localparam logic [5:0]  ANGLE_ADDR  = 6'h20;
    localparam logic [5:0]  CODE_ADDR   = 6'h3f;
    localparam logic [15:0] ACCESS_DATA = 16'h62d2;
    localparam logic [15:0] EXIT_DATA   = 16'h0000;

    // Hold limits in SENT ticks
    localparam logic [TICK_W-1:0] SENT_HOLD_MIN = 9'h01e;
    localparam logic [TICK_W-1:0] SS_SHORT_MIN  = 9'h032;
    localparam logic [TICK_W-1:0] SS_SHORT_MAX  = 9'h053;
    localparam logic [TICK_W-1:0] SS_LONG_MIN   = 9'h0c4;
    localparam logic [TICK_W-1:0] SS_LONG_MAX   = 9'h129;
    localparam logic [TICK_W-1:0] AS_MIN        = 9'h032;
    localparam logic [TICK_W-1:0] AS_MAX        = 9'h050;

    typedef enum logic [2:0] {
        MODE_NONE   = 3'h0,
        MODE_PWM    = 3'h1,
        MODE_SENT   = 3'h2,
        MODE_TRIGGERED_SENT_VARIANT  = 3'h3,
        MODE_SSHORT = 3'h4,
        MODE_SLONG  = 3'h5,
        MODE_ALTERNATE_SENT_VARIANT  = 3'h6
    } out_mode_t;

    typedef enum logic [2:0] {
        M_IDLE   = 3'h0,
        M_HOLD   = 3'h1,
        M_GATE   = 3'h2,
        M_WAIT   = 3'h3,
        M_LOCKED = 3'h4,
        M_ACTIVE = 3'h5
    } mstate_t;

    typedef struct packed {
        logic       lead;
        logic       is_write;
        logic [5:0] addr;
        logic [7:0] data;
    } spi_cmd_t;

    typedef struct packed {
        logic        is_write;
        logic [3:0]  chip_sel;
        logic [5:0]  addr;
        logic [15:0] data;
    } mcmd_t;

    typedef struct packed {
        logic sclk;
        logic mosi;
        logic cs_b;
        logic line;
        logic die1;
        logic die0;
    } pins_t;

    localparam pins_t PINS_RST = 6'h0c;

endpackage

// ===== hw/crc4_calc.sv
`timescale 1ns/1ps
`default_nettype none

module crc4_calc (
    input  wire logic [15:0] data,
    output logic      [3:0]  crc
);

    always_comb begin
        logic fb;
        fb  = 1'b0;
        crc = ssap_pkg::CRC_PRESET;
        for (int i = ssap_pkg::FRAME_BITS - 1; i >= 0; i--) begin
            fb  = data[i] ^ crc[3];
            crc = {crc[2], crc[1], crc[0] ^ fb, fb};
        end
    end

endmodule // crc4_calc

`default_nettype wire

// ===== hw/sensor_serial_access_port.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Read takes two frames: select, then data
// - Sample on SCLK rise, act at CS rise
// - Select frame returns previously selected register
// - 16 data bits, MISO changes on SCLK fall
// - Even address whole word, odd byte only
// - CRC appended when more than 16 clocks
// - Host CRC ignored unless check enable set
// - Bad CRC frame discarded, warning flag set
// - CRC x^4+x+1, preset ones, MSB first
// - Feedback data XOR C3, shift with taps
// - Manchester zero rising, one falling, MSB first
// - Die address from two die-address pins
// - Manchester disable ignores every Manchester command
// - No angle output: entry code alone starts
// - Aux pulse then code; timeout only in gate and wait, locked waits for code
// - Aux pulses ignored when aux enable clear
// - Entry stops angle data, only codes accepted
// - Access code opens, exit code restores output
// - PWM hold twice period, gate, timeout
// - Aux pulse widths per short, long, alternate
// - Access code is 0x62D2 to 0x3F
// - Exit code is 0x0000 to 0x3F
module sensor_serial_access_port #(
    parameter int ACCESS_TMO_CYC = ssap_pkg::ACCESS_TMO_CYC
) (
    input  wire logic                core_clk,
    input  wire logic                rst_b,
    input  wire logic                sclk,
    input  wire logic                mosi,
    input  wire logic                cs_b,
    output logic                     miso,
    output logic                     miso_oe_b,
    input  wire logic                output_line,
    input  wire logic                die_addr_bit0,
    input  wire logic                die_addr_bit1,
    input  wire logic                host_crc_check_enable,
    input  wire logic                manchester_disable,
    input  wire logic                spi_output_override,
    input  wire logic                aux_pulse_enable,
    input  wire ssap_pkg::out_mode_t out_mode,
    input  wire logic [15:0]         pwm_period_cycles,
    input  wire logic [8:0]          sent_tick_cycles,
    input  wire logic                mcmd_valid,
    input  wire ssap_pkg::mcmd_t     mcmd,
    input  wire logic [15:0]         reg_word,
    input  wire logic                crc_warn_clr,
    output logic [5:0]               reg_word_addr,
    output logic                     crc_warn,
    output logic                     angle_enable,
    output logic                     manch_engaged,
    output logic                     manch_active,
    output logic                     mcmd_fwd_valid,
    output ssap_pkg::mcmd_t          mcmd_fwd,
    output logic                     aux_timeout
);

    localparam logic [ssap_pkg::TMO_W-1:0] TMO_LAST =
        ssap_pkg::TMO_W'(ACCESS_TMO_CYC - 1);

    function automatic logic die_selected(input ssap_pkg::mcmd_t c,
                                          input logic [1:0] id);
        return (c.chip_sel == 4'h0) || c.chip_sel[id];
    endfunction

    function automatic logic is_code(input ssap_pkg::mcmd_t c,
                                     input logic [15:0] d);
        return c.is_write && (c.addr == ssap_pkg::CODE_ADDR)
               && (c.data == d);
    endfunction

    function automatic logic in_range(input logic [8:0] v,
                                      input logic [8:0] lo,
                                      input logic [8:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction

    function automatic logic hold_ok(
        input ssap_pkg::out_mode_t m,
        input logic [8:0]          t,
        input logic [17:0]         c,
        input logic [15:0]         per
    );
        case (m)
            ssap_pkg::MODE_PWM:
                return c >= {1'b0, per, 1'b0};
            ssap_pkg::MODE_SENT, ssap_pkg::MODE_TRIGGERED_SENT_VARIANT:
                return t >= ssap_pkg::SENT_HOLD_MIN;
            ssap_pkg::MODE_SSHORT:
                return in_range(t, ssap_pkg::SS_SHORT_MIN,
                                ssap_pkg::SS_SHORT_MAX);
            ssap_pkg::MODE_SLONG:
                return in_range(t, ssap_pkg::SS_LONG_MIN,
                                ssap_pkg::SS_LONG_MAX);
            ssap_pkg::MODE_ALTERNATE_SENT_VARIANT:
                return in_range(t, ssap_pkg::AS_MIN,
                                ssap_pkg::AS_MAX);
            default:
                return 1'b0;
        endcase
    endfunction

    ssap_pkg::pins_t s1_r;
    ssap_pkg::pins_t s2_r;
    ssap_pkg::pins_t s3_r;

    // Pins are asynchronous to core_clk; s1 feeds only s2
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_r <= ssap_pkg::PINS_RST;
            s2_r <= ssap_pkg::PINS_RST;
            s3_r <= ssap_pkg::PINS_RST;
        end else begin
            s1_r <= '{sclk: sclk, mosi: mosi, cs_b: cs_b,
                      line: output_line, die1: die_addr_bit1,
                      die0: die_addr_bit0};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic cs_fall;
    logic line_rise;
    logic line_fall;

    assign sclk_rise = s2_r.sclk & ~s3_r.sclk & ~s2_r.cs_b;
    assign sclk_fall = ~s2_r.sclk & s3_r.sclk & ~s2_r.cs_b;
    assign cs_rise   = s2_r.cs_b & ~s3_r.cs_b;
    assign cs_fall   = ~s2_r.cs_b & s3_r.cs_b;
    assign line_rise = s2_r.line & ~s3_r.line;
    assign line_fall = ~s2_r.line & s3_r.line;

    logic [ssap_pkg::FRAME_CRC_BITS-1:0] rx_sr_r;
    logic [ssap_pkg::BCNT_W-1:0]         bit_cnt_r;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_sr_r   <= '0;
            bit_cnt_r <= '0;
        end else if (cs_fall) begin
            bit_cnt_r <= '0;
        end else if (sclk_rise) begin
            rx_sr_r <= {rx_sr_r[ssap_pkg::FRAME_CRC_BITS-2:0],
                        s2_r.mosi};
            if (bit_cnt_r != ssap_pkg::BCNT_MAX) begin
                bit_cnt_r <= bit_cnt_r + 5'h01;
            end
        end
    end

    logic              frame16;
    logic              frame20;
    logic              frame_len_ok;
    ssap_pkg::spi_cmd_t cmd;
    logic [3:0]        crc_rx_calc;
    logic              crc_bad;
    logic              frame_ok;

    assign frame16      = bit_cnt_r == ssap_pkg::BCNT_16;
    assign frame20      = bit_cnt_r == ssap_pkg::BCNT_20;
    assign frame_len_ok = frame16 || frame20;
    assign cmd = frame20 ? rx_sr_r[ssap_pkg::FRAME_CRC_BITS-1:
                                   ssap_pkg::CRC_BITS]
                         : rx_sr_r[ssap_pkg::FRAME_BITS-1:0];

    crc4_calc u_crc_rx (
        .data (cmd),
        .crc  (crc_rx_calc)
    );

    // Trailing host CRC only matters when checking is enabled
    assign crc_bad  = frame20 && host_crc_check_enable
                      && (crc_rx_calc != rx_sr_r[3:0]);
    assign frame_ok = cs_rise && frame_len_ok && !crc_bad
                      && !cmd.lead;

    logic [5:0] sel_addr_r;
    logic [5:0] sel_addr_nxt;

    // A write frame falls back to the angle register
    assign sel_addr_nxt = cmd.is_write ? ssap_pkg::ANGLE_ADDR : cmd.addr;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_addr_r    <= ssap_pkg::ANGLE_ADDR;
            reg_word_addr <= ssap_pkg::ANGLE_ADDR;
        end else if (frame_ok) begin
            sel_addr_r    <= sel_addr_nxt;
            reg_word_addr <= {sel_addr_nxt[5:1], 1'b0};
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            crc_warn <= 1'b0;
        end else if (cs_rise && frame_len_ok && crc_bad) begin
            crc_warn <= 1'b1;
        end else if (crc_warn_clr) begin
            crc_warn <= 1'b0;
        end
    end

    logic [15:0]                         out_word;
    logic [3:0]                          crc_tx;
    logic [ssap_pkg::FRAME_CRC_BITS-1:0] tx_sr_r;

    assign out_word = sel_addr_r[0] ? {8'h00, reg_word[7:0]}
                                    : reg_word;

    crc4_calc u_crc_tx (
        .data (out_word),
        .crc  (crc_tx)
    );

    // CRC always rides behind the data; a 16-clock host just stops early
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_sr_r   <= '0;
            miso      <= 1'b0;
            miso_oe_b <= 1'b1;
        end else begin
            miso_oe_b <= s2_r.cs_b;
            if (cs_fall) begin
                tx_sr_r <= {out_word, crc_tx};
                miso    <= out_word[15];
            end else if (sclk_fall) begin
                tx_sr_r <= {tx_sr_r[ssap_pkg::FRAME_CRC_BITS-2:0], 1'b0};
                miso    <= tx_sr_r[ssap_pkg::FRAME_CRC_BITS-2];
            end
        end
    end

    // Bit-level decode of the line is upstream; mcmd is MSB-first fields
    logic [1:0] die_id;
    logic       cmd_hit;
    logic       acc;
    logic       ext;
    logic       blocked;
    logic       aux_armed;

    assign die_id    = {s2_r.die1, s2_r.die0};
    assign cmd_hit   = mcmd_valid && die_selected(mcmd, die_id);
    assign acc       = cmd_hit
                       && is_code(mcmd, ssap_pkg::ACCESS_DATA);
    assign ext       = cmd_hit
                       && is_code(mcmd, ssap_pkg::EXIT_DATA);
    assign blocked   = manchester_disable || spi_output_override;
    assign aux_armed = aux_pulse_enable
                       && (out_mode != ssap_pkg::MODE_NONE);

    ssap_pkg::mstate_t st_r;
    ssap_pkg::mstate_t st_nxt;
    logic [ssap_pkg::CNT_W-1:0]  cyc_cnt_r;
    logic [ssap_pkg::TICK_W-1:0] tick_div_r;
    logic [ssap_pkg::TICK_W-1:0] ticks_r;
    logic [ssap_pkg::TMO_W-1:0]  tmo_cnt_r;
    logic                        tick_en;
    logic                        tmo_hit;
    logic                        waiting;

    assign tick_en = tick_div_r >= (sent_tick_cycles - 9'h001);
    assign waiting = (st_r == ssap_pkg::M_GATE)
                     || (st_r == ssap_pkg::M_WAIT);
    assign tmo_hit = waiting && (tmo_cnt_r >= TMO_LAST);

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ssap_pkg::M_IDLE: begin
                if (aux_armed && line_fall) begin
                    st_nxt = ssap_pkg::M_HOLD;
                end else if (out_mode == ssap_pkg::MODE_NONE && acc) begin
                    st_nxt = ssap_pkg::M_ACTIVE;
                end
            end
            ssap_pkg::M_HOLD: begin
                if (line_rise) begin
                    st_nxt = hold_ok(out_mode, ticks_r, cyc_cnt_r,
                                     pwm_period_cycles)
                             ? ssap_pkg::M_GATE : ssap_pkg::M_IDLE;
                end
            end
            ssap_pkg::M_GATE: begin
                if (tmo_hit) begin
                    st_nxt = ssap_pkg::M_IDLE;
                end else if (line_fall) begin
                    st_nxt = (cyc_cnt_r >= ssap_pkg::GATE_CYC_V)
                             ? ssap_pkg::M_WAIT : ssap_pkg::M_IDLE;
                end
            end
            ssap_pkg::M_WAIT: begin
                if (tmo_hit) begin
                    st_nxt = ssap_pkg::M_IDLE;
                end else if (line_rise) begin
                    st_nxt = (cyc_cnt_r >= ssap_pkg::GATE_CYC_V)
                             ? ssap_pkg::M_LOCKED : ssap_pkg::M_IDLE;
                end
            end
            ssap_pkg::M_LOCKED: begin
                if (acc) begin
                    st_nxt = ssap_pkg::M_ACTIVE;
                end else if (ext) begin
                    st_nxt = ssap_pkg::M_IDLE;
                end
            end
            ssap_pkg::M_ACTIVE: begin
                if (ext) begin
                    st_nxt = ssap_pkg::M_IDLE;
                end
            end
            default: st_nxt = ssap_pkg::M_IDLE;
        endcase
        // Override or disable drops the link whatever it was doing
        if (blocked) begin
            st_nxt = ssap_pkg::M_IDLE;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= ssap_pkg::M_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Pulse width and gate timers restart on every state change
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cyc_cnt_r  <= '0;
            tick_div_r <= '0;
            ticks_r    <= '0;
        end else if (st_nxt != st_r) begin
            cyc_cnt_r  <= '0;
            tick_div_r <= '0;
            ticks_r    <= '0;
        end else begin
            if (cyc_cnt_r != '1) begin
                cyc_cnt_r <= cyc_cnt_r + 18'h00001;
            end
            tick_div_r <= tick_en ? 9'h000 : tick_div_r + 9'h001;
            if (tick_en && ticks_r != '1) begin
                ticks_r <= ticks_r + 9'h001;
            end
        end
    end

    // Timeout runs from the end of the hold across gate and wait
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tmo_cnt_r <= '0;
        end else if (st_r == ssap_pkg::M_HOLD) begin
            tmo_cnt_r <= '0;
        end else if (waiting && !tmo_hit) begin
            tmo_cnt_r <= tmo_cnt_r + 14'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            angle_enable   <= 1'b1;
            manch_engaged  <= 1'b0;
            manch_active   <= 1'b0;
            mcmd_fwd_valid <= 1'b0;
            mcmd_fwd       <= '0;
            aux_timeout    <= 1'b0;
        end else begin
            angle_enable   <= (st_nxt == ssap_pkg::M_IDLE)
                              || (st_nxt == ssap_pkg::M_HOLD);
            manch_engaged  <= (st_nxt == ssap_pkg::M_LOCKED)
                              || (st_nxt == ssap_pkg::M_ACTIVE);
            manch_active   <= st_nxt == ssap_pkg::M_ACTIVE;
            mcmd_fwd_valid <= (st_r == ssap_pkg::M_ACTIVE) && cmd_hit
                              && !ext && !blocked;
            mcmd_fwd       <= mcmd;
            aux_timeout    <= tmo_hit && !blocked;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_aux_accept;
        (st_r == ssap_pkg::M_HOLD) && (st_nxt == ssap_pkg::M_GATE);
    endsequence

    sequence s_leave;
        ((st_r == ssap_pkg::M_ACTIVE) || (st_r == ssap_pkg::M_LOCKED))
        && ext && !blocked;
    endsequence

    read_select_a: assert property (
        frame_ok && !cmd.is_write |=> sel_addr_r == $past(cmd.addr))
        else $error("read frame did not select its address");
    write_angle_a: assert property (
        frame_ok && cmd.is_write |=> sel_addr_r == ssap_pkg::ANGLE_ADDR)
        else $error("write frame did not select angle register");
    crc_discard_a: assert property (
        cs_rise && frame_len_ok && crc_bad
        |=> crc_warn && $stable(sel_addr_r))
        else $error("bad crc frame not discarded or flagged");
    crc_ignore_a: assert property (
        cs_rise && frame20 && !host_crc_check_enable && !cmd.lead
        |=> !$rose(crc_warn))
        else $error("host crc checked while disabled");
    odd_byte_a: assert property (
        cs_fall && sel_addr_r[0] |=> tx_sr_r[19:12] == 8'h00 && !miso)
        else $error("odd address upper byte not zero");
    miso_edge_a: assert property (
        !cs_fall && !sclk_fall |=> $stable(miso))
        else $error("miso changed off a falling sclk edge");
    angle_stop_a: assert property (
        s_aux_accept |=> !angle_enable ##1 !angle_enable || !waiting)
        else $error("angle data not stopped on entry");
    tmo_return_a: assert property (
        tmo_hit && !blocked |=> st_r == ssap_pkg::M_IDLE && angle_enable)
        else $error("access code timeout did not restore output");
    man_disable_a: assert property (
        manchester_disable |=> st_r == ssap_pkg::M_IDLE && !manch_active)
        else $error("manchester active while disabled");
    aux_off_a: assert property (
        st_r == ssap_pkg::M_IDLE && !aux_pulse_enable
        |=> st_r != ssap_pkg::M_HOLD)
        else $error("aux pulse seen while disabled");
    exit_code_a: assert property (
        s_leave |=> st_r == ssap_pkg::M_IDLE && angle_enable)
        else $error("exit code did not restore output");

endmodule // sensor_serial_access_port

`default_nettype wire

// ===== verif/ssap_host.sv
`timescale 1ns/1ps
`default_nettype none

module ssap_host (
    output logic      sclk,
    output logic      mosi,
    output logic      cs_b,
    input  wire logic miso,
    input  wire logic miso_oe_b
);
    initial begin
        sclk = 1'b0;
        mosi = 1'b1;
        cs_b = 1'b1;
    end

    // Mode 0 host, clock parked low outside frames
    task automatic xfer(input logic [19:0] tx, input int n,
                        output logic [19:0] rx);
        rx = '0;
        cs_b = 1'b0;
        #150;
        for (int i = n - 1; i >= 0; i--) begin
            mosi = tx[i];
            #100 sclk = 1'b1;
            // Undriven miso counts as unknown
            rx = {rx[18:0], miso_oe_b ? 1'bx : miso};
            #100 sclk = 1'b0;
        end
        #100 cs_b = 1'b1;
        mosi = ~mosi;
        #250;
    endtask
endmodule // ssap_host

`default_nettype wire

// ===== verif/sensor_serial_access_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module sensor_serial_access_port_tb_top;
    logic core_clk, rst_b, output_line, die_addr_bit0, die_addr_bit1;
    logic host_crc_check_enable, manchester_disable, aux_pulse_enable;
    logic mcmd_valid, crc_warn_clr, sclk, mosi, cs_b, miso, miso_oe_b;
    logic crc_warn, angle_enable, manch_engaged, manch_active;
    logic mcmd_fwd_valid, aux_timeout, spi_output_override;
    logic [8:0]          sent_tick_cycles;
    logic [27:0]         fwd;
    logic [15:0]         pwm_period_cycles, reg_word;
    logic [5:0]          reg_word_addr;
    ssap_pkg::out_mode_t out_mode;
    ssap_pkg::mcmd_t     mcmd, mcmd_fwd;
    int failures = 0, n_compared = 0, cyc = 0, seed = 32'ha31698a9;

    sensor_serial_access_port #(.ACCESS_TMO_CYC(200))
        sensor_serial_access_port_i (.core_clk, .rst_b, .sclk, .mosi,
        .cs_b, .miso, .miso_oe_b, .output_line, .die_addr_bit0,
        .die_addr_bit1, .host_crc_check_enable, .manchester_disable,
        .spi_output_override, .aux_pulse_enable, .out_mode,
        .pwm_period_cycles, .sent_tick_cycles, .mcmd_valid, .mcmd,
        .reg_word, .crc_warn_clr, .reg_word_addr, .crc_warn, .angle_enable,
        .manch_engaged, .manch_active, .mcmd_fwd_valid, .mcmd_fwd,
        .aux_timeout);
    ssap_host ssap_host_i (.sclk, .mosi, .cs_b, .miso, .miso_oe_b);

    function automatic logic [15:0] word(input logic [5:0] a);
        return {a, 2'b01, ~a, 2'b10};
    endfunction
    assign reg_word = word(reg_word_addr);
    function automatic logic [15:0] exp_rd(input logic [5:0] a);
        logic [15:0] w;
        w = word({a[5:1], 1'b0});
        return a[0] ? {8'h00, w[7:0]} : w;
    endfunction
    function automatic logic [3:0] crc4(input logic [15:0] d);
        logic [3:0] c;
        logic       f;
        c = 4'hf;
        for (int i = 15; i >= 0; i--) begin
            f = d[i] ^ c[3];
            c = {c[2], c[1], c[0] ^ f, f};
        end
        return c;
    endfunction

    task automatic chk(input logic [19:0] got, exp, input string m);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("failures %0d compared %0d", failures, n_compared);
        if (failures == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Frame of 16 or 20 bits, CRC optionally corrupted
    task automatic xf(input logic [15:0] c, input int n, input logic bad,
                      output logic [19:0] rx);
        logic [19:0] tx;
        tx = {c, crc4(c) ^ {3'b000, bad}};
        ssap_host_i.xfer(n == 16 ? {4'h0, c} : tx, n, rx);
    endtask
    task automatic cmd(input ssap_pkg::mcmd_t m);
        @(posedge core_clk) #1;
        mcmd = m;
        mcmd_valid = 1'b1;
        @(posedge core_clk) #1;
        fwd = {mcmd_fwd_valid, mcmd_fwd};
        mcmd_valid = 1'b0;
        @(posedge core_clk) #1;
    endtask
    task automatic line(input logic v, input int n);
        output_line = v;
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic aux(input int lo, gap);
        line(1'b0, lo);
        line(1'b1, 45);
        line(1'b0, gap);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            finish_test();
        end
    end

    initial begin
        logic [19:0] rx;
        logic [5:0]  a, prev;
        {rst_b, die_addr_bit0, host_crc_check_enable} = '0;
        {manchester_disable, mcmd_valid, crc_warn_clr} = '0;
        {output_line, die_addr_bit1, aux_pulse_enable} = 3'b111;
        out_mode = ssap_pkg::MODE_NONE;
        pwm_period_cycles = 16'h000a;
        spi_output_override = 1'b0;
        sent_tick_cycles = 9'h002;
        mcmd = '0;
        repeat (5) @(posedge core_clk);
        #1 rst_b = 1'b1;
        repeat (6) @(posedge core_clk);
        #1;
        xf(16'h2400, 16, 1'b0, rx);
        prev = 6'h24;
        for (int k = 0; k < 8; k++) begin
            a = (k == 0) ? 6'h25 : 6'($random(seed));
            xf({2'b00, a, 8'h00}, 16, 1'b0, rx);
            chk(rx, {4'h0, exp_rd(prev)}, "select frame");
            xf({2'b00, a, 8'h00}, 20, 1'b0, rx);
            chk(rx, {exp_rd(a), crc4(exp_rd(a))}, "data");
            prev = a;
        end
        xf(16'h505a, 16, 1'b0, rx);
        xf(16'h2400, 16, 1'b0, rx);
        chk(rx, {4'h0, exp_rd(6'h20)}, "after write");
        host_crc_check_enable = 1'b1;
        xf(16'h2600, 20, 1'b1, rx);
        chk(20'(crc_warn), 20'h1, "warn set");
        xf(16'h2800, 20, 1'b0, rx);
        chk(20'(rx[19:4]), 20'(exp_rd(6'h24)), "discarded");
        @(posedge core_clk) #1 crc_warn_clr = 1'b1;
        @(posedge core_clk) #1 crc_warn_clr = 1'b0;
        @(posedge core_clk) #1 chk(20'(crc_warn), 20'h0, "warn clr");
        host_crc_check_enable = 1'b0;
        xf(16'h2b00, 20, 1'b1, rx);
        xf(16'h2b00, 20, 1'b0, rx);
        chk(20'(rx[19:4]), 20'(exp_rd(6'h2b)), "crc ignored");
        cmd({1'b1, 4'b0010, 6'h3f, 16'h62d2});
        chk(20'(manch_active), 20'h0, "other die");
        manchester_disable = 1'b1;
        cmd({1'b1, 4'b0000, 6'h3f, 16'h62d2});
        chk(20'(manch_active), 20'h0, "disabled");
        manchester_disable = 1'b0;
        spi_output_override = 1'b1;
        cmd({1'b1, 4'b0000, 6'h3f, 16'h62d2});
        chk(20'(manch_active), 20'h0, "override");
        spi_output_override = 1'b0;
        cmd({1'b1, 4'b0100, 6'h3f, 16'h62d2});
        chk(20'(manch_active), 20'h1, "direct entry");
        cmd({1'b1, 4'b0000, 6'h3f, 16'h0000});
        chk(20'(manch_engaged), 20'h0, "exit");
        out_mode = ssap_pkg::MODE_PWM;
        aux_pulse_enable = 1'b0;
        aux(25, 45);
        line(1'b1, 10);
        chk(20'(manch_engaged), 20'h0, "aux off");
        aux_pulse_enable = 1'b1;
        aux(25, 45);
        line(1'b1, 5);
        chk({manch_engaged, angle_enable}, 20'h2, "locked");
        cmd({1'b1, 4'b0000, 6'h3f, 16'h62d2});
        chk(20'(manch_active), 20'h1, "access");
        cmd({1'b0, 4'b0000, 6'h12, 16'h5a3c});
        chk(20'(fwd[27:16]), 20'h00812, "fwd head");
        chk(20'(fwd[15:0]), 20'h05a3c, "fwd data");
        cmd({1'b1, 4'b0000, 6'h3f, 16'h0000});
        chk({manch_engaged, angle_enable}, 20'h1, "restored");
        chk(20'(fwd[27]), 20'h0, "exit kept");
        // Holds of about 100 ticks suit none of the windowed variants
        for (int m = 4; m < 7; m++) begin
            out_mode = ssap_pkg::out_mode_t'(m);
            line(1'b0, 200);
            line(1'b1, 45);
            chk({manch_engaged, angle_enable}, 20'h1, "width");
        end
        out_mode = ssap_pkg::MODE_SENT;
        aux(70, 10);
        for (int i = 0; i < 400 && aux_timeout !== 1'b1; i++)
            @(posedge core_clk) #1;
        chk(20'(aux_timeout), 20'h1, "timeout");
        line(1'b1, 5);
        chk(20'(angle_enable), 20'h1, "resumed");
        finish_test();
    end
endmodule // sensor_serial_access_port_tb_top

`default_nettype wire
